// [posax_pkg.sv]
// Shared constants and types of the two-axis positioning link
package posax_pkg;
  // ==========================================================
  // Commands and answers
  typedef enum logic [2:0] {
    read_state_bits_cmd,
    read_operation_info_cmd,
    read_encoder_cmd,
    float_origin_cmd,
    inching_move_cmd,
    clear_error_cmd
  } cmd_op_t;
  localparam int NUM_AXES = 2;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_BAD_CMD = 16'h0001;
  localparam logic [15:0] ERR_ORIGIN_BUSY = 16'h00d3;
  localparam logic [15:0] ERR_INCH_BUSY = 16'h0191;
  // State-bit layout inside the answer word, one byte per axis
  localparam int SB_IN_OP = 0;
  localparam int SB_ERROR = 1;
  localparam int SB_JOG = 2;
  localparam int SB_DIR = 3;
  localparam int SB_AXIS_STRIDE = 8;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int INCH_STEP_NS = 1000;
  localparam int JOG_SLOW_NS = 4000;
  localparam int JOG_FAST_NS = 400;
  localparam int SCAN_NS = 20000;
  localparam logic [15:0] INCH_STEP_CYC = 16'(INCH_STEP_NS / CLK_PERIOD_NS);
  localparam logic [15:0] JOG_SLOW_CYC = 16'(JOG_SLOW_NS / CLK_PERIOD_NS);
  localparam logic [15:0] JOG_FAST_CYC = 16'(JOG_FAST_NS / CLK_PERIOD_NS);
  localparam int SCAN_CYC_DEFAULT = SCAN_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_JOG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_ERR = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 4;
  localparam int CTRL_AXIS = 8;
  localparam int CTRL_BYPASS = 9;
  localparam int JOG_CW_LSB = 0;
  localparam int JOG_CCW_LSB = 2;
  localparam int JOG_FAST_LSB = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_READY = 2;
  localparam int ST_AXERR_LSB = 4;
  localparam int ST_JOG_LSB = 6;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_REFUSED = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage : posax_pkg

// [posax_if.sv]
// Link between the scan controller and the positioning device
`timescale 1ns/1ps
interface posax_if;
  import posax_pkg::*;
  logic cmd_valid;
  logic cmd_ready;
  cmd_op_t cmd_op;
  logic cmd_axis;
  logic [31:0] cmd_arg;
  logic ans_valid;
  logic ans_done;
  logic [15:0] ans_err;
  logic [31:0] ans_data;
  logic module_ready;
  logic [NUM_AXES-1:0] axis_error;
  logic [NUM_AXES-1:0] jog_active;
  logic scan_end;
  logic [NUM_AXES-1:0] jog_cw;
  logic [NUM_AXES-1:0] jog_ccw;
  logic [NUM_AXES-1:0] jog_fast;
  modport device (
    input cmd_valid, cmd_op, cmd_axis, cmd_arg, scan_end, jog_cw, jog_ccw, jog_fast,
    output cmd_ready, ans_valid, ans_done, ans_err, ans_data, module_ready, axis_error, jog_active
  );
  modport host (
    output cmd_valid, cmd_op, cmd_axis, cmd_arg, scan_end, jog_cw, jog_ccw, jog_fast,
    input cmd_ready, ans_valid, ans_done, ans_err, ans_data, module_ready, axis_error, jog_active
  );
endinterface : posax_if

// [axis_drive.sv]
// One axis: position counter, inching run and jog run with step output
`timescale 1ns/1ps
module axis_drive
  import posax_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halt,
  input wire logic origin_set,
  input wire logic inch_start,
  input wire logic [31:0] inch_amount,
  input wire logic jog_cw,
  input wire logic jog_ccw,
  input wire logic jog_fast,
  output logic [31:0] position,
  output logic in_operation,
  output logic jog_active,
  output logic step_pulse,
  output logic dir
);
  logic [31:0] remain;
  logic [15:0] timer;
  logic inching;
  logic jog_req;
  logic moving;
  logic tick;
  logic [15:0] period;
  logic [31:0] magnitude;

  // ==========================================================
  // Motion selection
  assign inching = remain != 32'h0000_0000;
  assign jog_req = (jog_cw ^ jog_ccw) && !halt && !inching; // R12
  assign moving = inching || jog_active;
  assign tick = moving && timer == 16'h0000;
  assign period = inching ? INCH_STEP_CYC : (jog_fast ? JOG_FAST_CYC : JOG_SLOW_CYC); // R12
  assign magnitude = inch_amount[31] ? 32'(-inch_amount) : inch_amount;
  assign in_operation = moving;

  // ==========================================================
  // Step generation; jog speed changes take effect on the next reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position <= 32'h0000_0000;
      remain <= 32'h0000_0000;
      timer <= 16'h0000;
      jog_active <= 1'b0;
      step_pulse <= 1'b0;
      dir <= 1'b0;
    end else begin
      jog_active <= jog_req; // R14
      step_pulse <= tick;
      if (halt) begin
        remain <= 32'h0000_0000;
      end else if (inch_start) begin
        remain <= magnitude; // R10
        dir <= inch_amount[31];
      end else if (tick && inching) begin
        remain <= remain - 32'h0000_0001;
      end
      if (jog_req) begin
        dir <= jog_ccw;
      end
      // An inching run starts a full inching period from its own start, not from an idle jog reload
      if (inch_start) begin
        timer <= INCH_STEP_CYC - 16'h0001; // R10
      end else begin
        timer <= tick || !moving ? period - 16'h0001 : timer - 16'h0001;
      end
      if (origin_set) begin
        position <= 32'h0000_0000;
      end else if (tick) begin
        position <= dir ? position - 32'h0000_0001 : position + 32'h0000_0001;
      end
    end
  end
endmodule : axis_drive

// [pos_device.sv]
// Positioning device end: command interpreter, axis status and jog intake
//
// Contract
// R01 - Ready only while no error is detected
// R02 - Axis selector 0 is X, 1 is Y
// R03 - Done goes 1 on success, 0 on error
// R04 - Failed command shows its numeric error code
// R05 - State read returns in-operation and error bits
// R06 - Info read returns selected axis current position
// R07 - Encoder read returns count with done/error
// R08 - Origin set while axis runs fails 211
// R09 - Inching while axis runs fails 401
// R10 - Accepted inching moves by commanded amount
// R11 - Host gates commands on clear error bit
// R12 - Jog driven by direction and speed bits
// R13 - Jog bits transferred once per scan end
// R14 - Jog-operating bit raised; changes accepted mid-jog
// R15 - New command clears done and error outputs
`timescale 1ns/1ps
module pos_device
  import posax_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  posax_if.device link,
  input wire logic [31:0] encoder_count,
  input wire logic [NUM_AXES-1:0] axis_fault_pin,
  output logic [NUM_AXES-1:0] step,
  output logic [NUM_AXES-1:0] dir
);
  typedef enum logic [1:0] {st_idle, st_exec, st_answer} dev_state_t;

  dev_state_t state;
  dev_state_t next_state;
  cmd_op_t op;
  logic axis;
  logic [31:0] arg;
  logic done;
  logic [15:0] err_code;
  logic [31:0] data;
  logic answer;
  logic [NUM_AXES-1:0] fault_meta;
  logic [NUM_AXES-1:0] fault_sync;
  logic [NUM_AXES-1:0] axis_error;
  logic [NUM_AXES-1:0] jog_cw;
  logic [NUM_AXES-1:0] jog_ccw;
  logic [NUM_AXES-1:0] jog_fast;
  logic [NUM_AXES-1:0] in_op;
  logic [NUM_AXES-1:0] jog_act;
  logic [NUM_AXES-1:0] origin_set;
  logic [NUM_AXES-1:0] inch_start;
  logic [31:0] position [NUM_AXES];
  logic [31:0] state_bits;
  logic accept;
  logic sel_busy;
  logic exec;
  logic run_origin;
  logic run_inch;
  logic run_clear;
  logic [15:0] exec_err;
  logic [31:0] exec_data;
  logic ready;

  function automatic logic [NUM_AXES-1:0] axis_onehot(input logic sel);
    axis_onehot = sel ? 2'b10 : 2'b01; // R02
  endfunction : axis_onehot

  // ==========================================================
  // Fault pins and error latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_meta <= 2'b00;
      fault_sync <= 2'b00;
    end else begin
      fault_meta <= axis_fault_pin;
      fault_sync <= fault_meta;
    end
  end

  // A fault arriving with the clear command keeps the axis in error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axis_error <= 2'b00;
    end else begin
      axis_error <= fault_sync | (run_clear ? 2'b00 : axis_error);
    end
  end

  // Ready appears one cycle after reset release unless an axis holds an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready <= 1'b0;
    end else begin
      ready <= ~|axis_error; // R01
    end
  end

  // ==========================================================
  // Jog bits sampled only on the scan-end strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jog_cw <= 2'b00;
      jog_ccw <= 2'b00;
      jog_fast <= 2'b00;
    end else if (link.scan_end) begin
      jog_cw <= link.jog_cw; // R13
      jog_ccw <= link.jog_ccw; // R13
      jog_fast <= link.jog_fast; // R13
    end
  end

  // ==========================================================
  // Axes
  assign origin_set = run_origin ? axis_onehot(axis) : 2'b00;
  assign inch_start = run_inch ? axis_onehot(axis) : 2'b00;

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      axis_drive u_axis (
        .aclk(aclk),
        .aresetn(aresetn),
        .halt(axis_error[g]),
        .origin_set(origin_set[g]),
        .inch_start(inch_start[g]),
        .inch_amount(arg),
        .jog_cw(jog_cw[g]), // R12
        .jog_ccw(jog_ccw[g]), // R12
        .jog_fast(jog_fast[g]), // R12
        .position(position[g]),
        .in_operation(in_op[g]),
        .jog_active(jog_act[g]),
        .step_pulse(step[g]),
        .dir(dir[g])
      );
      assign state_bits[g*SB_AXIS_STRIDE+SB_IN_OP] = in_op[g]; // R05
      assign state_bits[g*SB_AXIS_STRIDE+SB_ERROR] = axis_error[g]; // R05
      assign state_bits[g*SB_AXIS_STRIDE+SB_JOG] = jog_act[g];
      assign state_bits[g*SB_AXIS_STRIDE+SB_DIR] = dir[g];
      assign state_bits[g*SB_AXIS_STRIDE+SB_AXIS_STRIDE-1:g*SB_AXIS_STRIDE+SB_DIR+1] = 4'h0;
    end
  endgenerate
  assign state_bits[31:NUM_AXES*SB_AXIS_STRIDE] = 16'h0000;

  // ==========================================================
  // Command execution
  assign accept = state == st_idle && link.cmd_valid;
  assign exec = state == st_exec;
  assign sel_busy = axis ? in_op[1] : in_op[0];
  assign run_origin = exec && op == float_origin_cmd && !sel_busy;
  assign run_inch = exec && op == inching_move_cmd && !sel_busy; // R10
  assign run_clear = exec && op == clear_error_cmd;

  always_comb begin
    exec_err = ERR_NONE;
    exec_data = 32'h0000_0000;
    case (op)
      read_state_bits_cmd: exec_data = state_bits; // R05
      read_operation_info_cmd: exec_data = position[axis]; // R06
      read_encoder_cmd: exec_data = encoder_count; // R07
      float_origin_cmd: exec_err = sel_busy ? ERR_ORIGIN_BUSY : ERR_NONE; // R08
      inching_move_cmd: exec_err = sel_busy ? ERR_INCH_BUSY : ERR_NONE; // R09
      clear_error_cmd: exec_err = ERR_NONE;
      default: exec_err = ERR_BAD_CMD;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      st_idle: next_state = accept ? st_exec : st_idle;
      st_exec: next_state = st_answer;
      st_answer: next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      op <= read_state_bits_cmd;
      axis <= 1'b0;
      arg <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (accept) begin
        op <= link.cmd_op;
        axis <= link.cmd_axis; // R02
        arg <= link.cmd_arg;
      end
    end
  end

  // Results stand until the next command is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      err_code <= ERR_NONE;
      data <= 32'h0000_0000;
      answer <= 1'b0;
    end else begin
      answer <= exec;
      if (accept) begin
        done <= 1'b0; // R15
        err_code <= ERR_NONE; // R15
      end else if (exec) begin
        done <= exec_err == ERR_NONE; // R03
        err_code <= exec_err; // R04
        data <= exec_data; // R07
      end
    end
  end

  // ==========================================================
  // Link outputs
  assign link.cmd_ready = state == st_idle;
  assign link.ans_valid = answer;
  assign link.ans_done = done;
  assign link.ans_err = err_code;
  assign link.ans_data = data;
  assign link.module_ready = ready;
  assign link.axis_error = axis_error;
  assign link.jog_active = jog_act; // R14
endmodule : pos_device

// [pos_host.sv]
// Scan controller end: AXI4-Lite registers, command issue and jog refresh
`timescale 1ns/1ps
module pos_host
  import posax_pkg::*;
#(
  parameter int SCAN_CYC = SCAN_CYC_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  posax_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  logic aw_held;
  logic w_held;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic do_write;
  logic rd_hs;
  logic rd_irq;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [3:0] op_field;
  logic cmd_axis;
  logic bypass;
  logic [31:0] arg;
  logic [5:0] jog_reg;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic busy;
  logic [15:0] last_err;
  logic [31:0] last_data;
  logic go;
  logic motion_op;
  logic refuse;
  logic [31:0] scan_cnt;

  // ==========================================================
  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        waddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        wdata <= s_axi_wdata;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        if (s_axi_bvalid) begin
          aw_held <= 1'b0;
          w_held <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read; unmapped addresses answer SLVERR with zero data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hs = s_axi_arvalid && !s_axi_rvalid;
  assign rd_irq = rd_hs && s_axi_araddr == REG_IRQ_STAT;
  assign rd_ok = s_axi_araddr <= REG_IRQ_MASK && s_axi_araddr[1:0] == 2'b00;
  assign rd_mux =
    s_axi_araddr == REG_CTRL ? {22'h0, bypass, cmd_axis, op_field, 3'h0, busy} :
    s_axi_araddr == REG_ARG ? arg :
    s_axi_araddr == REG_JOG ? {26'h0, jog_reg} :
    s_axi_araddr == REG_STATUS ? {24'h0, link.jog_active, link.axis_error, 1'b0,
                                  link.module_ready, link.ans_done, busy} :
    s_axi_araddr == REG_ERR ? {16'h0, last_err} :
    s_axi_araddr == REG_DATA ? last_data :
    s_axi_araddr == REG_IRQ_STAT ? {29'h0, irq_stat} :
    s_axi_araddr == REG_IRQ_MASK ? {29'h0, irq_mask} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rd_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers and command issue
  assign go = do_write && waddr == REG_CTRL && wdata[CTRL_GO] && s_axi_wstrb[0] && !busy;
  assign motion_op = cmd_op_t'(wdata[CTRL_OP_LSB+:3]) == float_origin_cmd
                  || cmd_op_t'(wdata[CTRL_OP_LSB+:3]) == inching_move_cmd;
  // Motion orders toward a faulted axis stop here unless the interlock is bypassed
  assign refuse = go && motion_op && !wdata[CTRL_BYPASS] && link.axis_error[wdata[CTRL_AXIS]]; // R11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_field <= 4'h0;
      cmd_axis <= 1'b0;
      bypass <= 1'b0;
      arg <= 32'h0000_0000;
      jog_reg <= 6'h00;
      irq_mask <= IRQ_RESET;
      busy <= 1'b0;
      link.cmd_valid <= 1'b0;
      link.cmd_op <= read_state_bits_cmd;
      link.cmd_axis <= 1'b0;
      link.cmd_arg <= 32'h0000_0000;
      last_err <= ERR_NONE;
      last_data <= 32'h0000_0000;
    end else begin
      if (do_write && waddr == REG_CTRL && s_axi_wstrb[1]) begin
        cmd_axis <= wdata[CTRL_AXIS];
        bypass <= wdata[CTRL_BYPASS];
      end
      if (do_write && waddr == REG_CTRL && s_axi_wstrb[0]) begin
        op_field <= wdata[CTRL_OP_LSB+:4];
      end
      if (do_write && waddr == REG_ARG) begin
        arg <= wdata;
      end
      if (do_write && waddr == REG_JOG && s_axi_wstrb[0]) begin
        jog_reg <= wdata[5:0]; // R12
      end
      if (do_write && waddr == REG_IRQ_MASK && s_axi_wstrb[0]) begin
        irq_mask <= wdata[2:0];
      end
      if (go && !refuse) begin
        busy <= 1'b1;
        link.cmd_valid <= 1'b1;
        link.cmd_op <= cmd_op_t'(wdata[CTRL_OP_LSB+:3]);
        link.cmd_axis <= wdata[CTRL_AXIS]; // R02
        link.cmd_arg <= arg;
      end else if (link.cmd_valid && link.cmd_ready) begin
        link.cmd_valid <= 1'b0;
      end
      if (link.ans_valid) begin
        busy <= 1'b0;
        last_err <= link.ans_err;
        last_data <= link.ans_data;
      end
    end
  end

  // ==========================================================
  // Sticky events; a read clears them but a same-cycle event survives
  assign irq_set = {refuse, link.ans_valid && !link.ans_done, link.ans_valid && link.ans_done};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= IRQ_RESET;
    end else begin
      irq_stat <= irq_set | (rd_irq ? 3'h0 : irq_stat);
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // Scan cycle: jog bits settle one cycle ahead of the scan-end strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_cnt <= 32'h0000_0000;
      link.scan_end <= 1'b0;
      link.jog_cw <= 2'b00;
      link.jog_ccw <= 2'b00;
      link.jog_fast <= 2'b00;
    end else begin
      scan_cnt <= scan_cnt == 32'(SCAN_CYC - 1) ? 32'h0000_0000 : scan_cnt + 32'h0000_0001;
      link.scan_end <= scan_cnt == 32'h0000_0000; // R13
      if (scan_cnt == 32'(SCAN_CYC - 1)) begin
        link.jog_cw <= jog_reg[JOG_CW_LSB+:2]; // R13
        link.jog_ccw <= jog_reg[JOG_CCW_LSB+:2];
        link.jog_fast <= jog_reg[JOG_FAST_LSB+:2];
      end
    end
  end
endmodule : pos_host

// [posax_props.sv]
// Concurrent checks on the link between scan controller and positioning device
`timescale 1ns/1ps
module posax_props
  import posax_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire cmd_op_t cmd_op,
  input wire logic cmd_axis,
  input wire logic ans_valid,
  input wire logic ans_done,
  input wire logic [15:0] ans_err,
  input wire logic module_ready,
  input wire logic [NUM_AXES-1:0] axis_error,
  input wire logic [NUM_AXES-1:0] jog_active,
  input wire logic scan_end,
  input wire logic [NUM_AXES-1:0] jog_cw,
  input wire logic [NUM_AXES-1:0] jog_ccw
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Command handshake
  sequence s_accept;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_busy_axis(cmd_op_t op);
    s_accept ##0 (cmd_op == op && jog_active[cmd_axis]);
  endsequence
  a_new_clears: assert property (s_accept |=> !ans_done && ans_err == ERR_NONE)
    else $error("done or error not cleared on accept");
  a_ans_window: assert property (s_accept |-> ##[1:3] ans_valid)
    else $error("no answer after accept");
  a_busy_gap: assert property (s_accept |=> !cmd_ready [*2])
    else $error("device ready while executing");
  a_done_err: assert property (ans_valid |-> ans_done == (ans_err == ERR_NONE))
    else $error("done and error code disagree");
  a_req_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op) && $stable(cmd_axis))
    else $error("request dropped or changed before accept");
  a_origin_busy: assert property (s_busy_axis(float_origin_cmd) |-> ##[1:3] ans_valid && ans_err == ERR_ORIGIN_BUSY)
    else $error("origin set on running axis not refused");
  a_inch_busy: assert property (s_busy_axis(inching_move_cmd) |-> ##[1:3] ans_valid && ans_err == ERR_INCH_BUSY)
    else $error("inching on running axis not refused");
  // ==========================================================
  // Readiness and jog exchange
  a_ready_err: assert property (axis_error != 0 ##1 axis_error != 0 |-> !module_ready)
    else $error("ready while an axis error is latched");
  a_scan_gap: assert property (scan_end |=> !scan_end [*8])
    else $error("scan end pulses too close");
  a_jog_change: assert property ($changed({jog_cw, jog_ccw}) |-> ##[0:1] scan_end)
    else $error("jog bits changed away from scan end");
  a_jog_stop: assert property (scan_end && !(jog_cw[0] ^ jog_ccw[0]) |-> ##[1:2] !jog_active[0])
    else $error("jog still active without one direction");
endmodule : posax_props

// [positioning_axis_command_interface_tb.sv]
// Self-checking bench: controller and device joined, driven over AXI4-Lite
`timescale 1ns/1ps
module positioning_axis_command_interface_tb;
  import posax_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, enc, rv, amt;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, fault;
  int fails, total_checks;
  posax_if link();
  pos_host #(.SCAN_CYC(20)) i_pos_host (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  pos_device i_pos_device (.aclk(aclk), .aresetn(aresetn), .link(link), .encoder_count(enc),
    .axis_fault_pin(fault), .step(), .dir());
  posax_props i_posax_props (.aclk(aclk), .aresetn(aresetn), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_op(link.cmd_op), .cmd_axis(link.cmd_axis), .ans_valid(link.ans_valid),
    .ans_done(link.ans_done), .ans_err(link.ans_err), .module_ready(link.module_ready),
    .axis_error(link.axis_error), .jog_active(link.jog_active), .scan_end(link.scan_end),
    .jog_cw(link.jog_cw), .jog_ccw(link.jog_ccw));
  // ==========================================================
  // Clock, watchdog, helpers
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    summarize();
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] f_ctrl(input cmd_op_t op, input logic ax, input logic byp);
    return (32'(byp) << CTRL_BYPASS) | (32'(ax) << CTRL_AXIS) | (32'(op) << CTRL_OP_LSB) | 32'h1;
  endfunction : f_ctrl
  function automatic logic [31:0] f_jog(input logic [1:0] cw, input logic [1:0] ccw, input logic [1:0] fast);
    return (32'(cw) << JOG_CW_LSB) | (32'(ccw) << JOG_CCW_LSB) | (32'(fast) << JOG_FAST_LSB);
  endfunction : f_jog
  // Handshakes are judged at the falling edge, where comb readys have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic cmd(input cmd_op_t op, input logic ax, input logic byp);
    wr(REG_CTRL, f_ctrl(op, ax, byp));
    rd(REG_STATUS);
    while (rv[ST_BUSY]) rd(REG_STATUS);
  endtask : cmd
  task automatic res(input logic [15:0] e);
    rd(REG_ERR);
    chk(rv, 32'(e));
    rd(REG_STATUS);
    chk(32'(rv[ST_DONE]), 32'(e == ERR_NONE));
  endtask : res
  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, enc, fault} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h7886));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_STATUS);
    chk(32'(rv[ST_READY]), 32'h1);
    rd(8'h20);
    chk(32'(rr), 32'h2);
    wr(REG_IRQ_MASK, 32'h6);
    for (int i = 0; i < 4; i++) begin
      enc <= $urandom;
      cmd(read_encoder_cmd, 1'($urandom_range(1)), 1'b0);
      rd(REG_DATA);
      chk(rv, enc);
      res(ERR_NONE);
    end
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h7);
    @(posedge aclk);
    chk(32'(irq), 32'h1);
    rd(REG_IRQ_STAT);
    chk(32'(rv[IRQ_DONE]), 32'h1);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    cmd(cmd_op_t'(3'h6), 1'b0, 1'b0);
    res(ERR_BAD_CMD);
    amt = 32'(1 + $urandom_range(2));
    wr(REG_ARG, amt);
    cmd(inching_move_cmd, 1'b0, 1'b0);
    res(ERR_NONE);
    cmd(inching_move_cmd, 1'b0, 1'b0);
    res(ERR_INCH_BUSY);
    cmd(float_origin_cmd, 1'b0, 1'b0);
    res(ERR_ORIGIN_BUSY);
    cmd(read_state_bits_cmd, 1'b0, 1'b0);
    rd(REG_DATA);
    chk(32'(rv[SB_IN_OP]), 32'h1);
    cmd(float_origin_cmd, 1'b1, 1'b0);
    res(ERR_NONE);
    repeat (amt * INCH_STEP_CYC + 100) @(posedge aclk);
    cmd(read_operation_info_cmd, 1'b0, 1'b0);
    rd(REG_DATA);
    chk(rv, amt);
    wr(REG_JOG, f_jog(2'b01, 2'b00, 2'b01));
    repeat (60) @(posedge aclk);
    rd(REG_STATUS);
    chk(32'(rv[ST_JOG_LSB]), 32'h1);
    cmd(inching_move_cmd, 1'b0, 1'b0);
    res(ERR_INCH_BUSY);
    cmd(float_origin_cmd, 1'b0, 1'b0);
    res(ERR_ORIGIN_BUSY);
    wr(REG_JOG, f_jog(2'b01, 2'b00, 2'b00));
    repeat (60) @(posedge aclk);
    rd(REG_STATUS);
    chk(32'(rv[ST_JOG_LSB]), 32'h1);
    wr(REG_JOG, 32'h0);
    repeat (60) @(posedge aclk);
    rd(REG_STATUS);
    chk(32'(rv[ST_JOG_LSB]), 32'h0);
    fault <= 2'b10;
    repeat (6) @(posedge aclk);
    rd(REG_STATUS);
    chk(32'(rv[ST_READY]), 32'h0);
    chk(32'(rv[ST_AXERR_LSB + 1]), 32'h1);
    wr(REG_CTRL, f_ctrl(float_origin_cmd, 1'b1, 1'b0));
    rd(REG_IRQ_STAT);
    chk(32'(rv[IRQ_REFUSED]), 32'h1);
    fault <= 2'b00;
    repeat (4) @(posedge aclk);
    cmd(clear_error_cmd, 1'b1, 1'b1);
    rd(REG_STATUS);
    chk(32'(rv[ST_READY]), 32'h1);
    summarize();
  end
endmodule : positioning_axis_command_interface_tb
